// >>> inc/fhr_pkg.sv
// Package: widths, ranges and carrier types for the fault history recorder
package fhr_pkg;
	localparam int SLOTS = 10;
	localparam int SLOT_IDX_W = 4;
	localparam int CODE_W = 7;
	localparam int HOURS_W = 15;
	localparam int MIN_W = 12;
	localparam int FREQ_W = 16;
	localparam int CURR_W = 16;
	localparam int BUS_W = 11;
	localparam int STAT_W = 5;
	localparam logic [CODE_W-1:0] CODE_MAX = 7'h7f;
	localparam logic [HOURS_W-1:0] HOURS_MAX = 15'h7fff;
	localparam logic [MIN_W-1:0] MIN_MAX = 12'hc80;
	localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hc350;
	localparam logic [BUS_W-1:0] BUS_MAX = 11'h4b0;
	localparam logic [STAT_W-1:0] STAT_MAX = 5'h1f;
	localparam logic [SLOT_IDX_W-1:0] SLOT_FIRST = 4'h1;
	localparam logic [SLOT_IDX_W-1:0] SLOT_LAST = 4'ha;

	typedef struct packed {
		logic [HOURS_W-1:0] hours;
		logic [MIN_W-1:0] minutes;
		logic [FREQ_W-1:0] freq;
		logic [CURR_W-1:0] current;
		logic [BUS_W-1:0] busVolts;
		logic [STAT_W-1:0] status;
	} fhr_snap_type;

	typedef struct packed {
		logic valid;
		logic [CODE_W-1:0] code;
		fhr_snap_type snap;
	} fhr_entry_type;

	localparam fhr_entry_type ENTRY_RESET = '0;
endpackage : fhr_pkg

// >>> rtl/fhr_slot.sv
// One history slot: loads either a new entry or its upstream neighbour
`timescale 1ns/1ps
`default_nettype none
module fhr_slot
(
	// Clocking
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// Shift control
	input wire logic shiftEn,
	input var fhr_pkg::fhr_entry_type entryIn,
	// Stored entry
	output var fhr_pkg::fhr_entry_type entryOut
);
	fhr_pkg::fhr_entry_type entry_reg;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			entry_reg <= fhr_pkg::ENTRY_RESET;
		else if (clkEn && shiftEn)
			entry_reg <= entryIn;
	end

	assign entryOut = entry_reg;
endmodule : fhr_slot
`default_nettype wire

// >>> rtl/fault_history_recorder.sv
// Fault history recorder: ten-deep log of fault codes with live snapshots
// Contract
// - Ten slots by age, slot 1 newest
// - Fault repeating the newest code in slot 1 is logged only once
// - Capture elapsed hours, 0 to 32767
// - Capture elapsed minutes in tenths, 0-320.0
// - Capture output frequency, hundredths Hz, 0-500
// - Capture output current in hundredths ampere
// - Capture DC bus volts, 0 to 1200
// - Capture five-bit drive status word
// - Snapshots stay aligned with code order
`timescale 1ns/1ps
`default_nettype none
module fault_history_recorder
(
	// Clocking
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// Fault event from detection logic
	input wire logic faultEvent,
	input wire logic [fhr_pkg::CODE_W-1:0] faultCode,
	// Live measurements
	input wire logic [fhr_pkg::HOURS_W-1:0] elapsed_hours_value,
	input wire logic [fhr_pkg::MIN_W-1:0] elapsed_minutes_value,
	input wire logic [fhr_pkg::FREQ_W-1:0] output_frequency_value,
	input wire logic [fhr_pkg::CURR_W-1:0] output_current_value,
	input wire logic [fhr_pkg::BUS_W-1:0] dc_bus_voltage_value,
	input wire logic [fhr_pkg::STAT_W-1:0] drive_status_word,
	// History read port, slot 1 is index 1
	input wire logic [fhr_pkg::SLOT_IDX_W-1:0] readSlot,
	output var fhr_pkg::fhr_entry_type readEntry,
	output logic [fhr_pkg::CODE_W-1:0] newest_fault_code_slot,
	output logic logged
);
	// ****************************************
	// Declarations
	// ****************************************
	fhr_pkg::fhr_entry_type newEntry;
	fhr_pkg::fhr_entry_type chain [0:fhr_pkg::SLOTS];
	fhr_pkg::fhr_entry_type readNext;

	// Per-field snapshot values
	logic [fhr_pkg::CODE_W-1:0] codeClamp;
	logic [fhr_pkg::HOURS_W-1:0] hoursClamp;
	logic [fhr_pkg::MIN_W-1:0] minutesClamp;
	logic [fhr_pkg::FREQ_W-1:0] freqClamp;
	logic [fhr_pkg::CURR_W-1:0] currentPass;
	logic [fhr_pkg::BUS_W-1:0] busClamp;
	logic [fhr_pkg::STAT_W-1:0] statusMask;

	// Control
	logic isRepeat;
	logic logNext;
	logic doLog;

	// Read path
	logic readInRange;

	// ****************************************
	// Snapshot clamping
	// ****************************************
	// Out-of-range readings other than current are clamped so no other field of a slot holds an impossible value
	// Seven bits already span every legal code
	always_comb
	begin
		codeClamp = faultCode;
	end

	always_comb
	begin
		if (elapsed_hours_value > fhr_pkg::HOURS_MAX)
		begin
			hoursClamp = fhr_pkg::HOURS_MAX;
		end
		else
		begin
			hoursClamp = elapsed_hours_value;
		end
	end

	always_comb
	begin
		if (elapsed_minutes_value > fhr_pkg::MIN_MAX)
		begin
			minutesClamp = fhr_pkg::MIN_MAX;
		end
		else
		begin
			minutesClamp = elapsed_minutes_value;
		end
	end

	always_comb
	begin
		if (output_frequency_value > fhr_pkg::FREQ_MAX)
		begin
			freqClamp = fhr_pkg::FREQ_MAX;
		end
		else
		begin
			freqClamp = output_frequency_value;
		end
	end

	// No clamp on current: its ceiling scales with the drive rating
	always_comb
	begin
		currentPass = output_current_value;
	end

	always_comb
	begin
		if (dc_bus_voltage_value > fhr_pkg::BUS_MAX)
		begin
			busClamp = fhr_pkg::BUS_MAX;
		end
		else
		begin
			busClamp = dc_bus_voltage_value;
		end
	end

	always_comb
	begin
		statusMask = drive_status_word & fhr_pkg::STAT_MAX;
	end

	// ****************************************
	// Entry assembly
	// ****************************************
	// Code and snapshot share one word so they cannot drift apart
	always_comb
	begin
		newEntry.valid = 1'b1;
		newEntry.code = codeClamp;
		newEntry.snap.hours = hoursClamp;
		newEntry.snap.minutes = minutesClamp;
		newEntry.snap.freq = freqClamp;
		newEntry.snap.current = currentPass;
		newEntry.snap.busVolts = busClamp;
		newEntry.snap.status = statusMask;
	end

	// ****************************************
	// Repeat filter
	// ****************************************
	// Only slot 1 is compared; an older code returning is a new event
	assign isRepeat = chain[1].valid && (chain[1].code == newEntry.code);
	assign logNext = faultEvent && !isRepeat;
	assign doLog = clkEn && logNext;
	assign chain[0] = newEntry;

	// ****************************************
	// Shift chain of history slots
	// ****************************************
	// Whole entries move together, keeping every field with its code
	genvar g;
	generate
		for (g = 1; g <= fhr_pkg::SLOTS; g++)
		begin : gSlot
			fhr_slot uSlot
			(
				.clk_sys(clk_sys),
				.srst(srst),
				.clkEn(clkEn),
				.shiftEn(doLog),
				.entryIn(chain[g-1]),
				.entryOut(chain[g])
			);
		end
	endgenerate

	// ****************************************
	// Read side
	// ****************************************
	// No write path exists into the slots
	// Unused indices read as an empty entry rather than aliasing a slot
	assign readInRange = (readSlot >= fhr_pkg::SLOT_FIRST) && (readSlot <= fhr_pkg::SLOT_LAST);

	always_comb
	begin
		if (readInRange)
		begin
			readNext = chain[readSlot];
		end
		else
		begin
			readNext = fhr_pkg::ENTRY_RESET;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			readEntry <= fhr_pkg::ENTRY_RESET;
		end
		else if (clkEn)
		begin
			readEntry <= readNext;
		end
	end

	// ****************************************
	// Logged strobe
	// ****************************************
	// One cycle per accepted fault; a held event is filtered as a repeat
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			logged <= 1'b0;
		end
		else if (clkEn)
		begin
			logged <= logNext;
		end
	end

	// ****************************************
	// Newest code
	// ****************************************
	assign newest_fault_code_slot = chain[1].code;
endmodule : fault_history_recorder
`default_nettype wire

// >>> test/fhr_asserts.sv
// Checker: port assertions for the fault history recorder
`timescale 1ns/1ps
`default_nettype none
module fhr_asserts
(
	// Clocking
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// Fault event
	input wire logic faultEvent,
	input wire logic [fhr_pkg::CODE_W-1:0] faultCode,
	// Observed outputs
	input wire logic logged,
	input wire logic [fhr_pkg::CODE_W-1:0] newest_fault_code_slot,
	input wire logic [fhr_pkg::SLOT_IDX_W-1:0] readSlot,
	input var fhr_pkg::fhr_entry_type readEntry
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire logic h = clkEn && faultEvent;
	wire logic [fhr_pkg::CODE_W-1:0] n = newest_fault_code_slot;
	property p_new; h && faultCode != n |=> logged; endproperty
	a_new: assert property (p_new) else $error("fault not logged");
	property p_rep; logged && h && faultCode == n |=> !logged; endproperty
	a_rep: assert property (p_rep) else $error("repeat logged");
	property p_top; logged && $past(clkEn) |-> n == $past(faultCode); endproperty
	a_top: assert property (p_top) else $error("newest code wrong");
	property p_chg; !$past(srst) && $changed(n) |-> logged; endproperty
	a_chg: assert property (p_chg) else $error("newest moved");
	property p_one; logged && clkEn && !faultEvent |=> !logged; endproperty
	a_one: assert property (p_one) else $error("log pulse held");
	property p_off; clkEn && (readSlot == 4'h0 || readSlot > 4'ha) |=> readEntry == fhr_pkg::ENTRY_RESET; endproperty
	a_off: assert property (p_off) else $error("bad slot data");
	property p_rd; clkEn && readSlot == 4'h1 |=> readEntry.code == $past(n); endproperty
	a_rd: assert property (p_rd) else $error("slot one code");
	property p_val; $rose(logged) |-> $past(h); endproperty
	a_val: assert property (p_val) else $error("stray log");
endmodule : fhr_asserts
bind fault_history_recorder fhr_asserts ua
(
	.clk_sys(clk_sys),
	.srst(srst),
	.clkEn(clkEn),
	.faultEvent(faultEvent),
	.faultCode(faultCode),
	.logged(logged),
	.newest_fault_code_slot(newest_fault_code_slot),
	.readSlot(readSlot),
	.readEntry(readEntry)
);
`default_nettype wire

// >>> test/fhr_partner.sv
// Partner: fault source whose live measurements follow the code
`timescale 1ns/1ps
`default_nettype none
module fhr_partner
(
	// Fault request from the bench: event bit over code
	input wire logic [7:0] fq,
	// Fault event and code
	output logic ev,
	output logic [fhr_pkg::CODE_W-1:0] fc,
	// Live measurements that follow the code
	output var fhr_pkg::fhr_snap_type sn
);
	assign {ev, fc} = fq;
	assign sn = {8'h55, fc, 5'h0a, fc, 9'h0f0, fc, 9'h1c1, fc, 4'h8, fc, fc[4:0]};
endmodule : fhr_partner
`default_nettype wire

// >>> test/fault_history_recorder_bench.sv
// Bench: fault history recorder scenarios
`timescale 1ns/1ps
`default_nettype none
module fault_history_recorder_bench;
	logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, ev, logged;
	logic [7:0] fq = '0;
	logic [6:0] fc, nw;
	logic [3:0] rs = '0;
	fhr_pkg::fhr_snap_type sn;
	fhr_pkg::fhr_entry_type re;
	int fails = 0, totalChecks = 0;
	always #12.5 clk_sys = ~clk_sys;
	fhr_partner prt(.fq, .ev, .fc, .sn);
	fault_history_recorder uut(.clk_sys, .srst, .clkEn(ce), .faultEvent(ev), .faultCode(fc),
		.elapsed_hours_value(sn.hours), .elapsed_minutes_value(sn.minutes),
		.output_frequency_value(sn.freq), .output_current_value(sn.current),
		.dc_bus_voltage_value(sn.busVolts), .drive_status_word(sn.status),
		.readSlot(rs), .readEntry(re), .newest_fault_code_slot(nw), .logged);
	function logic [90:0] ex(logic l, logic [6:0] n, c, logic v);
		return {l, n, {83{v}} & {v, c, 8'h55, c, 5'h0a, c, 9'h0f0, c, 9'h1c1, c, 4'h8, c, c[4:0]}};
	endfunction : ex
	task check(string name, logic [90:0] seen, logic [90:0] expected);
		totalChecks++;
		if (seen !== expected)
		begin
			fails++;
			$display("[FAIL] %s exp %h seen %h", name, expected, seen);
		end
	endtask : check
	task go(logic [7:0] f, logic [3:0] s, logic [90:0] e);
		fq = f;
		rs = s;
		@(posedge clk_sys) #1;
		check("state", {logged, nw, re}, e);
	endtask : go
	task tFill;
		go(8'h80, 1, ex(1, 0, 0, 0));
		for (int c = 116; c < 128; c++)
			go({1'b1, 7'(c)}, 0, ex(1, 7'(c), 0, 0));
		for (int s = 0; s < 12; s++)
			go(0, s[3:0], ex(0, 127, 7'(128 - s), s % 11 != 0));
		$display("fill test done");
	endtask : tFill
	task tRep;
		go(8'hff, 0, ex(0, 127, 0, 0));
		go(8'hfe, 0, ex(1, 126, 0, 0));
		go(8'hfe, 2, ex(0, 126, 127, 1));
		go(0, 10, ex(0, 126, 119, 1));
		$display("repeat test done");
	endtask : tRep
	task tHold;
		ce = 1'b0;
		go(8'h85, 1, ex(0, 126, 119, 1));
		ce = 1'b1;
		go(0, 1, ex(0, 126, 126, 1));
		$display("hold test done");
	endtask : tHold
	task tReset;
		srst = 1'b1;
		go(0, 1, ex(0, 0, 0, 0));
		srst = 1'b0;
		go(8'h83, 1, ex(1, 3, 0, 0));
		go(0, 1, ex(0, 3, 3, 1));
		$display("reset test done");
	endtask : tReset
	task finishTest;
		$display("checks %0d fails %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finishTest
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#1 srst = 0;
		tFill;
		tRep;
		tHold;
		tReset;
		finishTest;
	end
endmodule : fault_history_recorder_bench
`default_nettype wire
